/* File: logic/scrb_pkg.sv */
// Package for the serial control register bank: addresses, widths,
// reset contents and the carrier types shared by the bank and its users.
// Assumes one system clock; the serial pins are foreign to that clock.
package scrb_pkg;

    localparam int ADDR_W   = 7;
    localparam int OCTET_W  = 8;
    localparam int WR_COUNT = 22;               // Writable registers 0..21

    typedef logic [ADDR_W-1:0]                  scrb_addr_type;
    typedef logic [OCTET_W-1:0]                 scrb_octet_type;
    typedef logic [WR_COUNT-1:0][OCTET_W-1:0]   scrb_bank_type;
    typedef logic [2:0]                         scrb_bitcnt_type;

    // One sample of the three control pins
    typedef struct packed {
        logic sclk;
        logic sel;
        logic io;
    } scrb_serial_type;

    // Register addresses
    localparam scrb_addr_type MODE_POWER_CONTROL         = 7'h00;
    localparam scrb_addr_type RSSI_LOCK_FILTER_CONTROL   = 7'h01;
    localparam scrb_addr_type PATH_BYPASS_CONTROL        = 7'h02;
    localparam scrb_addr_type OSCILLATOR_BIAS_BAND       = 7'h03;
    localparam scrb_addr_type FIXED_ZERO_REGISTER        = 7'h04;
    localparam scrb_addr_type FIXED_PATTERN_REGISTER     = 7'h05;
    localparam scrb_addr_type BIT_SYNC_CLOCK_SELECT      = 7'h06;
    localparam scrb_addr_type BITRATE_REFERENCE_DIVIDER  = 7'h07;
    localparam scrb_addr_type SWITCHED_CAP_CLOCK_DIVIDER = 7'h08;
    localparam scrb_addr_type CRYSTAL_TRIM               = 7'h09;
    localparam scrb_addr_type SYNTH_SET0_SWALLOW_COUNT   = 7'h0A;
    localparam scrb_addr_type SYNTH_SET0_FEEDBACK_HIGH   = 7'h0B;
    localparam scrb_addr_type SYNTH_SET0_FEEDBACK_LOW    = 7'h0C;
    localparam scrb_addr_type SYNTH_SET0_REFERENCE_HIGH  = 7'h0D;
    localparam scrb_addr_type SYNTH_SET0_REFERENCE_LOW   = 7'h0E;
    localparam scrb_addr_type SYNTH_SET1_SWALLOW_COUNT   = 7'h0F;
    localparam scrb_addr_type SYNTH_SET1_FEEDBACK_HIGH   = 7'h10;
    localparam scrb_addr_type SYNTH_SET1_FEEDBACK_LOW    = 7'h11;
    localparam scrb_addr_type SYNTH_SET1_REFERENCE_HIGH  = 7'h12;
    localparam scrb_addr_type SYNTH_SET1_REFERENCE_LOW   = 7'h13;
    localparam scrb_addr_type FIXED_CONSTANT_REGISTER    = 7'h14;
    localparam scrb_addr_type FREQ_ERROR_COUNT_CONTROL   = 7'h15;
    localparam scrb_addr_type FREQ_ERROR_ESTIMATE        = 7'h16;

    localparam scrb_addr_type LAST_WRITABLE = FREQ_ERROR_COUNT_CONTROL;
    localparam scrb_addr_type READ_ONLY     = FREQ_ERROR_ESTIMATE;
    localparam scrb_addr_type ADDR_MAX      = 7'h7F;
    localparam scrb_addr_type ADDR_STEP     = 7'h01;

    localparam scrb_bitcnt_type BIT_FIRST = 3'h0;
    localparam scrb_bitcnt_type BIT_LAST  = 3'h7;
    localparam scrb_bitcnt_type BIT_STEP  = 3'h1;
    localparam logic            DIR_READ  = 1'b1;
    localparam scrb_octet_type  OCTET_ZERO = 8'h00;

    // Power-down encoding of the operating mode field sits in bits 2:1;
    // the fixed bits are set except in the fixed-zero register 4, which resets to zero; the rest are zero.
    localparam scrb_octet_type MODE_POWER_DOWN_RESET = 8'h01;
    localparam scrb_bank_type BANK_RESET = {
        8'h00, 8'hB5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'hC0, 8'h00, 8'h00,
        8'h10, 8'h00, 8'hC0, 8'h00, 8'h80, MODE_POWER_DOWN_RESET
    };

endpackage

/* File: logic/scrb_bank.sv */
// Serial control register bank: 3-wire slave and the applied registers.
// Assumes the host drives serial clock and select; both are sampled on
// clk, so the serial clock must stay well below a quarter of clk.
// Behaviour
// - Twenty-three eight-bit registers, all readable
// - Registers 0 to 21 writable, 22 read-only
// - Every access moves whole eight-bit octets
// - Serial clock ignored while select low
// - Select active high; rising starts sequence
// - Data captured on falling serial clock
// - Address octet: seven bits, then direction
// - Write may start at any writable address
// - Data octets msb first, addresses increment
// - Data line stays input during writes
// - Select release loads shifted settings
// - Single write is address plus one octet
// - Reset leaves the device powered down
// - Read: device drives on rising edges
// - First rising edge after address enables driver
// - Reads leave registers unchanged, auto-increment
`timescale 1ns/1ns
module scrb_bank (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    sclkPin,
    input  wire logic                    selPin,
    input  wire logic                    ioIn,
    output      logic                    ioOut,
    output      logic                    ioOe,
    input  wire scrb_pkg::scrb_octet_type freqErrorValue,
    output      scrb_pkg::scrb_bank_type bank,
    output      logic                    loadPulse
);
    import scrb_pkg::*;

    typedef enum logic [1:0] {
        IDLE,
        ADDRESS,
        WRITING,
        READING
    } scrb_state_type;

    scrb_serial_type pinMeta;
    scrb_serial_type pinSync;
    scrb_serial_type pinLast;
    scrb_state_type  state;
    scrb_bank_type   shadow;
    scrb_octet_type  rxShift;
    scrb_octet_type  txShift;
    scrb_addr_type   addr;
    scrb_bitcnt_type bitCnt;
    logic            txLoaded;

    // all 23 readable
    // Register read mux: writable bank, live estimate, zero beyond
    function automatic scrb_octet_type readByte(scrb_addr_type a,
                                                scrb_bank_type b,
                                                scrb_octet_type ro);
        if (a <= LAST_WRITABLE)
            return b[a[4:0]];
        else if (a == READ_ONLY)
            return ro;
        else
            return OCTET_ZERO;
    endfunction

    // Two flops per pin before anything looks at them
    always_ff @(posedge clk) begin
        pinMeta <= '{sclk: sclkPin, sel: selPin, io: ioIn};
        pinSync <= pinMeta;
        pinLast <= pinSync;
    end

    // Edge decode; gating by select
    wire selRise  = pinSync.sel & ~pinLast.sel;
    wire selFall  = ~pinSync.sel & pinLast.sel;
    wire selOn    = pinSync.sel & pinLast.sel;
    wire sclkFall = selOn & ~pinSync.sclk & pinLast.sclk;
    wire sclkRise = selOn & pinSync.sclk & ~pinLast.sclk;
    wire octetEnd = sclkFall & (bitCnt == BIT_LAST);
    wire scrb_octet_type rxByte = {rxShift[OCTET_W-2:0], pinSync.io};
    wire wrHit    = (state == WRITING) & octetEnd & (addr <= LAST_WRITABLE);
    wire scrb_addr_type nextAddr = (addr == ADDR_MAX) ? addr
                                                      : addr + ADDR_STEP;
    wire scrb_octet_type readNow = readByte(addr, bank, freqErrorValue);

    // Sequence state machine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= IDLE;
        end else if (selRise) begin
            state <= ADDRESS;
        end else if (selFall) begin
            state <= IDLE;
        end else if (octetEnd && state == ADDRESS) begin
            state <= (rxByte[0] == DIR_READ) ? READING : WRITING;
        end
    end

    // Bit counter and receive shifter; whole octets counted
    always_ff @(posedge clk) begin
        if (!rst_n || selRise) begin
            bitCnt  <= BIT_FIRST;
            rxShift <= OCTET_ZERO;
        end else if (sclkFall) begin
            bitCnt  <= bitCnt + BIT_STEP;
            rxShift <= rxByte;
        end
    end

    // Address capture and increment
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr <= MODE_POWER_CONTROL;
        end else if (octetEnd && state == ADDRESS) begin
            addr <= rxByte[OCTET_W-1:1];
        end else if (octetEnd && state != IDLE) begin
            addr <= nextAddr;
        end
    end

    // complete octets only land in shadow
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shadow <= BANK_RESET;
        end else if (wrHit) begin
            shadow[addr[4:0]] <= rxByte;
        end
    end

    // release loads settings; reset means power-down
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bank      <= BANK_RESET;
            loadPulse <= 1'b0;
        end else begin
            loadPulse <= selFall;
            if (selFall)
                bank <= shadow;
        end
    end

    // Read driver; off unless reading, first rise enables
    always_ff @(posedge clk) begin
        if (!rst_n || selFall || state != READING) begin
            ioOe     <= 1'b0;
            ioOut    <= 1'b0;
            txShift  <= OCTET_ZERO;
            txLoaded <= 1'b0;
        end else if (sclkRise) begin
            ioOe <= 1'b1;
            if (!txLoaded) begin
                ioOut    <= readNow[OCTET_W-1];
                txShift  <= {readNow[OCTET_W-2:0], 1'b0};
                txLoaded <= 1'b1;
            end else begin
                ioOut   <= txShift[OCTET_W-1];
                txShift <= {txShift[OCTET_W-2:0], 1'b0};
            end
        end else if (octetEnd) begin
            txLoaded <= 1'b0;
        end
    end

endmodule

/* File: bench/scrb_bank_props.sv */
// Checker for the bank's serial slave: reset, load and driver timing.
// Sees only the bank's ports; bound to every bank instance below.
`timescale 1ns/1ns
module scrb_bank_props (
    input wire logic                     clk,
    input wire logic                     rst_n,
    input wire logic                     sclkPin,
    input wire logic                     selPin,
    input wire logic                     ioIn,
    input wire logic                     ioOut,
    input wire logic                     ioOe,
    input wire scrb_pkg::scrb_octet_type freqErrorValue,
    input wire scrb_pkg::scrb_bank_type  bank,
    input wire logic                     loadPulse
);
    import scrb_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Select low long enough for the driver to have let go
    sequence selIdle; (!selPin)[*6]; endsequence
    // Serial clock seen low on two samples running
    sequence sclkLow2; (!sclkPin)[*2]; endsequence
    a_reset_bank: assert property (
        $rose(rst_n) |-> bank == BANK_RESET) else $error("bank not reset");
    a_reset_quiet: assert property (
        $rose(rst_n) |-> !ioOe && !loadPulse) else $error("busy at reset");
    a_load_single: assert property (
        loadPulse |=> !loadPulse) else $error("load longer than one cycle");
    a_load_cause: assert property (
        loadPulse |-> !selPin && ($past(selPin, 3) || $past(selPin, 4)
        || $past(selPin, 5))) else $error("load without select release");
    a_bank_on_load: assert property (
        $changed(bank) |-> ##[0:1] loadPulse) else $error("bank moved");
    a_idle_released: assert property (
        selIdle |-> !ioOe) else $error("data driven while unselected");
    a_oe_on_rise: assert property (
        $rose(ioOe) |-> selPin && $past(sclkPin, 2)) else $error("oe early");
    a_out_held_low: assert property (
        sclkLow2 ##0 (ioOe && $past(ioOe)) |-> $stable(ioOut))
        else $error("read data moved while serial clock low");
endmodule
bind scrb_bank scrb_bank_props u_props (.clk(clk), .rst_n(rst_n),
    .sclkPin(sclkPin), .selPin(selPin), .ioIn(ioIn), .ioOut(ioOut),
    .ioOe(ioOe), .freqErrorValue(freqErrorValue), .bank(bank),
    .loadPulse(loadPulse));

/* File: bench/scrb_host.sv */
// Host model: makes select, serial clock and data for whole frames.
// Assumes clk is the bank's clock; pins move on its falling edge.
`timescale 1ns/1ns
module scrb_host (
    input  wire logic clk,
    input  wire logic ioOut,
    input  wire logic ioOe,
    output      logic sclkPin,
    output      logic selPin,
    output      logic ioIn
);
    logic hostBit = 1'b0;
    logic hostEn  = 1'b1;
    logic lastBit = 1'b0;
    // Wire level; a released line flips so stale data cannot pass
    assign ioIn = ioOe ? ioOut : (hostEn ? hostBit : ~lastBit);
    always @(posedge clk) lastBit <= ioIn;
    initial begin
        sclkPin = 1'b0;
        selPin  = 1'b0;
    end
    // host clocks, sets data at rise, samples at fall
    task automatic frame(input logic [191:0] v, input int n,
                         input int drv, output logic [191:0] r);
        r = '0;
        selPin = 1'b1;
        repeat (3) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            hostEn  = (i < drv);
            hostBit = v[n-1-i];
            sclkPin = 1'b1;
            repeat (5) @(negedge clk);
            r = {r[190:0], ioIn};
            sclkPin = 1'b0;
            repeat (3) @(negedge clk);
        end
        selPin = 1'b0;
        hostEn = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    // Bus traffic for some other device while select stays low
    task automatic idle_clk();
        repeat (8) begin
            sclkPin = ~sclkPin;
            hostBit = ~hostBit;
            repeat (4) @(negedge clk);
        end
    endtask
endmodule

/* File: bench/scrb_bank_tb.sv */
// Bench for the serial control register bank driven by a host model.
// Assumes the host model moves all serial pins on falling clk edges.
`timescale 1ns/1ns
module scrb_bank_tb;
    import scrb_pkg::*;
    logic           clk, rst_n, sclkPin, selPin, ioIn, ioOut, ioOe;
    logic           loadPulse, seenLoad;
    scrb_octet_type freqErrorValue;
    scrb_bank_type  bank, expBank;
    logic [191:0]   r;
    int             fail_count = 0, compares = 0;

    scrb_bank u_dut (.clk(clk), .rst_n(rst_n), .sclkPin(sclkPin),
        .selPin(selPin), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
        .freqErrorValue(freqErrorValue), .bank(bank), .loadPulse(loadPulse));
    scrb_host u_host (.clk(clk), .ioOut(ioOut), .ioOe(ioOe),
        .sclkPin(sclkPin), .selPin(selPin), .ioIn(ioIn));
    // System clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Remember a load pulse since the last clear
    always @(posedge clk) if (loadPulse === 1'b1) seenLoad <= 1'b1;

    task automatic check(input string nm, input logic [7:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Whole applied bank against the mirror, catches stray writes
    task automatic cmp_all();
        for (int i = 0; i < WR_COUNT; i++) check("bank", bank[i], expBank[i]);
    endtask
    task automatic end_sim();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_single();
        seenLoad = 1'b0;
        u_host.frame(192'({7'h01, 1'b0, 8'h8D}), 16, 16, r);
        expBank[1] = 8'h8D;
        cmp_all();
        check("load", {7'h00, seenLoad}, 8'h01);
        $display("single write done");
    endtask
    // Runs past the last writable register into the read-only one
    // fixed constant of register 20 rewritten unchanged
    task automatic t_burst();
        u_host.frame(192'({7'h13, 1'b0, 32'h5AB50CEE}), 40, 40, r);
        expBank[19] = 8'h5A;
        expBank[21] = 8'h0C;
        cmp_all();
        u_host.frame(192'({7'h09, 1'b0, 8'h37, 4'hF}), 20, 20, r);
        expBank[9] = 8'h37;
        cmp_all();
        $display("burst write done");
    endtask
    task automatic t_read();
        freqErrorValue = 8'h3C;
        u_host.frame(192'({7'h15, 1'b1, 16'h0000}), 24, 8, r);
        check("rd21", r[15:8], expBank[21]);
        check("rd22", r[7:0], 8'h3C);
        cmp_all();
        u_host.idle_clk();
        cmp_all();
        $display("read and idle done");
    endtask
    initial begin
        rst_n = 1'b0;
        freqErrorValue = 8'h00;
        seenLoad = 1'b0;
        expBank = BANK_RESET;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        // host rewrites registers after reset in the scenarios
        cmp_all();
        check("oe", {7'h00, ioOe}, 8'h00);
        t_single();
        t_burst();
        t_read();
        end_sim();
    end
    // Hang guard, well beyond the under nine hundred cycles the tests need
    initial begin
        #1000000;
        fail_count++;
        end_sim();
    end
endmodule
